// >>> src/tcr_capture_reg.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_capture_reg (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Load
    input  wire logic        load,
    input  wire logic [15:0] din,
    // Held value
    output var  logic [15:0] dout_r
);
    import tcr_pkg::*;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout_r <= CAP_RST;
        end else if (load) begin
            dout_r <= din;
        end
    end

endmodule // tcr_capture_reg
`default_nettype wire

// >>> src/tcr_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_edge_detect (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Pin and edge choice
    input  wire logic       pin_in,
    input  wire logic [1:0] edge_sel,
    // Trigger
    output var  logic       hit_r
);
    import tcr_pkg::*;

    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic rise;
    logic fall;
    logic hit_nxt;

    // Only sync2 and prev are compared; sync1 feeds nothing else
    assign rise    = sync2_r & ~prev_r; // RULE12
    assign fall    = ~sync2_r & prev_r; // RULE12
    assign hit_nxt = (edge_sel == EDGE_RISE) ? rise :
                     (edge_sel == EDGE_FALL) ? fall : (rise | fall); // RULE5

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
            hit_r   <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
            hit_r   <= hit_nxt;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rise_held;
        ($rose(pin_in) && edge_sel == EDGE_RISE) ##1 (pin_in && edge_sel == EDGE_RISE) [*2];
    endsequence

    a_rise_gives_hit: assert property (s_rise_held |=> hit_r ##1 !hit_r) // RULE12
        else $error("rising edge did not give a single trigger");
    a_fall_ignored: assert property ( // RULE5
        ($fell(pin_in) && edge_sel == EDGE_RISE) ##1 (edge_sel == EDGE_RISE) [*2] |=> !hit_r)
        else $error("falling edge triggered in rising mode");

endmodule // tcr_edge_detect
`default_nettype wire

// >>> src/tcr_pkg.sv
//
// Behaviour
// RULE1: Reload enable set lets the counter load from the reload value registers.
// RULE2: Channel-2 enabled edge captures the count or reloads; disabled input ignored.
// RULE3: Channel-1 enabled edge captures the count or reloads; disabled input ignored.
// RULE4: Channel-0 enabled edge captures the count or reloads; disabled input ignored.
// RULE5: Each channel picks its trigger edge from its own two-bit field.
// RULE6: Capture reset set clears the counter once a capture has taken place.
// RULE7: Capture of the old count happens first; the reset follows after it.
// RULE8: Hardware sets the timer flag; it stays set until software writes zero.
// RULE9: Counter advances only while run control is set; halting keeps the count.
// RULE10: Select at 0 gives reload mode with overflow flag; 1 gives compare match.
// RULE11: Sixteen-bit up counter in two bytes, wrapping all ones to zero.
// RULE12: Capture inputs are synchronised and edges give one-cycle triggers.
package tcr_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] IDX_MODE     = 8'hC2;
    localparam logic [7:0] IDX_RUN      = 8'hC3;
    localparam logic [7:0] IDX_CNT_LO   = 8'hD0;
    localparam logic [7:0] IDX_CNT_HI   = 8'hD1;
    localparam logic [7:0] IDX_RLD_LO   = 8'hD2;
    localparam logic [7:0] IDX_RLD_HI   = 8'hD3;
    localparam logic [7:0] IDX_CAPCTL   = 8'hD4;
    localparam logic [7:0] IDX_CAP_BASE = 8'hD5;
    localparam logic [7:0] IDX_STAT     = 8'hDB;
    localparam logic [7:0] IDX_MASK     = 8'hDC;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int MODE_RLD_EN   = 7;
    localparam int MODE_CAPEN_LO = 4;
    localparam int MODE_CRST     = 3;
    localparam int RUN_FLAG      = 7;
    localparam int RUN_RUN       = 2;
    localparam int RUN_CMP       = 0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [4:0]  MODE_RST   = 5'h00;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [15:0] RLD_RST    = 16'h0000;
    localparam logic [5:0]  CAPCTL_RST = 6'h00;
    localparam logic [15:0] CAP_RST    = 16'h0000;
    localparam logic [3:0]  IRQ_RST    = 4'h0;

    // ****************************************************************
    // Edge type codes
    // ****************************************************************
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam int          NUM_CH  = 3;

endpackage

// >>> src/tcr_timer.sv
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tcr_timer #(
    parameter int CHANNELS = tcr_pkg::NUM_CH
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Capture inputs
    input  wire logic        capture_input_ch0,
    input  wire logic        capture_input_ch1,
    input  wire logic        capture_input_ch2,
    // Events
    output var  logic        timer_event_flag,
    output var  logic        irq
);
    import tcr_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (CHANNELS != NUM_CH) begin : g_bad_ch
        $error("register map serves exactly three capture channels");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    logic [4:0]  mode_r;
    logic        run_r;
    logic        cmp_sel_r;
    logic [15:0] cnt_r;
    logic [15:0] rld_r;
    logic [5:0]  capctl_r;
    logic [3:0]  stat_r;
    logic [3:0]  mask_r;

    logic [2:0]  pin_vec;
    logic [2:0]  edge_hit;
    logic [15:0] cap_val [3];

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic [7:0]  idx;
    logic        page_ok;
    logic        hit_mode;
    logic        hit_run;
    logic        hit_cnt_lo;
    logic        hit_cnt_hi;
    logic        hit_rld_lo;
    logic        hit_rld_hi;
    logic        hit_capctl;
    logic        hit_cap;
    logic        hit_stat;
    logic        hit_mask;
    logic        mapped;
    logic [7:0]  cap_off;
    logic        setup;
    logic        wr_go;
    logic [7:0]  wbyte;

    assign idx        = paddr[9:2];
    assign page_ok    = (paddr[11:10] == 2'h0);
    assign hit_mode   = page_ok && (idx == IDX_MODE);
    assign hit_run    = page_ok && (idx == IDX_RUN);
    assign hit_cnt_lo = page_ok && (idx == IDX_CNT_LO);
    assign hit_cnt_hi = page_ok && (idx == IDX_CNT_HI);
    assign hit_rld_lo = page_ok && (idx == IDX_RLD_LO);
    assign hit_rld_hi = page_ok && (idx == IDX_RLD_HI);
    assign hit_capctl = page_ok && (idx == IDX_CAPCTL);
    assign cap_off    = idx - IDX_CAP_BASE;
    assign hit_cap    = page_ok && (idx >= IDX_CAP_BASE) && (cap_off < 8'h06);
    assign hit_stat   = page_ok && (idx == IDX_STAT);
    assign hit_mask   = page_ok && (idx == IDX_MASK);
    assign mapped     = hit_mode | hit_run | hit_cnt_lo | hit_cnt_hi | hit_rld_lo
                      | hit_rld_hi | hit_capctl | hit_cap | hit_stat | hit_mask;
    assign setup      = psel & ~penable;
    // A write lands only on the edge that completes the access
    assign wr_go      = psel & penable & pwrite & pready & ~pslverr;
    assign wbyte      = pwdata[7:0];

    logic wr_mode;
    logic wr_run;
    logic wr_cnt_lo;
    logic wr_cnt_hi;
    logic wr_rld_lo;
    logic wr_rld_hi;
    logic wr_capctl;
    logic wr_stat;
    logic wr_mask;
    logic cnt_wr;

    assign wr_mode   = wr_go & hit_mode;
    assign wr_run    = wr_go & hit_run;
    assign wr_cnt_lo = wr_go & hit_cnt_lo;
    assign wr_cnt_hi = wr_go & hit_cnt_hi;
    assign wr_rld_lo = wr_go & hit_rld_lo;
    assign wr_rld_hi = wr_go & hit_rld_hi;
    assign wr_capctl = wr_go & hit_capctl;
    assign wr_stat   = wr_go & hit_stat;
    assign wr_mask   = wr_go & hit_mask;
    assign cnt_wr    = wr_cnt_lo | wr_cnt_hi;

    // ****************************************************************
    // Capture channels
    // ****************************************************************
    logic       rld_en;
    logic       crst_en;
    logic [2:0] capen;
    logic [2:0] trig;
    logic [2:0] cap_ev;
    logic       reload_hit;
    logic       cap_any;

    assign pin_vec = {capture_input_ch2, capture_input_ch1, capture_input_ch0};
    assign rld_en  = mode_r[MODE_RLD_EN - 3];
    assign crst_en = mode_r[MODE_CRST - 3];
    assign capen   = mode_r[MODE_CAPEN_LO - 3 +: 3];

    for (genvar i = 0; i < 3; i++) begin : g_ch
        tcr_edge_detect u_edge (
            .pclk     (pclk),
            .presetn  (presetn),
            .pin_in   (pin_vec[i]),
            .edge_sel (capctl_r[2*i +: 2]),
            .hit_r    (edge_hit[i])
        );
        // A disabled channel's edges are dropped here
        assign trig[i]   = edge_hit[i] & capen[i]; // RULE2 RULE3 RULE4
        // With reload enabled an edge reloads instead of capturing
        assign cap_ev[i] = trig[i] & ~rld_en; // RULE2 RULE3 RULE4
        tcr_capture_reg u_cap (
            .pclk    (pclk),
            .presetn (presetn),
            .load    (cap_ev[i]),
            .din     (cnt_r),
            .dout_r  (cap_val[i])
        );
    end

    assign reload_hit = |trig & rld_en; // RULE1
    assign cap_any    = |cap_ev;

    // ****************************************************************
    // Counter
    // ****************************************************************
    logic        at_max;
    logic        inc_path;
    logic        ovf_ev;
    logic        cmp_ev;
    logic        flag_set;
    logic        flag_clr;
    logic        flag_nxt;
    logic [15:0] cnt_nxt;

    assign at_max   = (cnt_r == CNT_MAX);
    assign inc_path = run_r & ~cnt_wr & ~reload_hit & ~(cap_any & crst_en); // RULE9
    assign ovf_ev   = inc_path & at_max & ~cmp_sel_r; // RULE10
    assign cmp_ev   = run_r & cmp_sel_r & (cnt_r == rld_r); // RULE10
    assign flag_set = ovf_ev | cmp_ev; // RULE8
    assign flag_clr = wr_run & ~wbyte[RUN_FLAG];
    // Set wins over a clear in the same cycle
    assign flag_nxt = flag_set | (timer_event_flag & ~flag_clr); // RULE8

    // Capture has already taken the old count when the reset lands
    assign cnt_nxt = wr_cnt_lo  ? {cnt_r[15:8], wbyte} :
                     wr_cnt_hi  ? {wbyte, cnt_r[7:0]} :
                     reload_hit ? rld_r : // RULE1
                     (cap_any & crst_en) ? CNT_RST : // RULE6 RULE7
                     (inc_path & at_max & rld_en) ? rld_r : // RULE1
                     inc_path   ? cnt_r + 16'h0001 : // RULE11
                     cnt_r; // RULE9

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r            <= CNT_RST;
            timer_event_flag <= 1'b0;
        end else begin
            cnt_r            <= cnt_nxt;
            timer_event_flag <= flag_nxt;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r    <= MODE_RST;
            run_r     <= 1'b0;
            cmp_sel_r <= 1'b0;
            rld_r     <= RLD_RST;
            capctl_r  <= CAPCTL_RST;
            mask_r    <= IRQ_RST;
        end else begin
            if (wr_mode) mode_r <= wbyte[7:3];
            if (wr_run) begin
                run_r     <= wbyte[RUN_RUN];
                cmp_sel_r <= wbyte[RUN_CMP];
            end
            if (wr_rld_lo) rld_r[7:0] <= wbyte;
            if (wr_rld_hi) rld_r[15:8] <= wbyte;
            if (wr_capctl) capctl_r <= wbyte[5:0];
            if (wr_mask) mask_r <= wbyte[3:0];
        end
    end

    // ****************************************************************
    // Interrupt status
    // ****************************************************************
    logic [3:0] stat_set;
    logic [3:0] stat_nxt;

    assign stat_set = {cap_ev, flag_set};
    assign stat_nxt = stat_set | (stat_r & ~({4{wr_stat}} & wbyte[3:0]));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= IRQ_RST;
            irq    <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq    <= |(stat_nxt & mask_r);
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [15:0] cap_sel;
    logic [7:0]  cap_byte;
    logic [7:0]  rd_byte;

    assign cap_sel  = cap_val[cap_off[2:1] == 2'h0 ? 0 : (cap_off[2:1] == 2'h1 ? 1 : 2)];
    assign cap_byte = cap_off[0] ? cap_sel[15:8] : cap_sel[7:0];
    assign rd_byte  = hit_mode   ? {mode_r, 3'h0} :
                      hit_run    ? {timer_event_flag, 4'h0, run_r, 1'b0, cmp_sel_r} :
                      hit_cnt_lo ? cnt_r[7:0] :
                      hit_cnt_hi ? cnt_r[15:8] :
                      hit_rld_lo ? rld_r[7:0] :
                      hit_rld_hi ? rld_r[15:8] :
                      hit_capctl ? {2'h0, capctl_r} :
                      hit_cap    ? cap_byte :
                      hit_stat   ? {4'h0, stat_r} :
                      hit_mask   ? {4'h0, mask_r} : 8'h00;

    // Ready is raised in setup so every access finishes with no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= (setup & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_capture_reset;
        cap_any && crst_en && !cnt_wr && !reload_hit;
    endsequence

    a_halt_keeps_count: assert property ( // RULE9
        !run_r && !cnt_wr && trig == 3'h0 |=> $stable(cnt_r))
        else $error("count moved while halted");
    a_run_increments: assert property ( // RULE11
        inc_path && !at_max |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("running count did not step by one");
    a_wrap_to_zero: assert property ( // RULE11
        inc_path && at_max && !rld_en |=> cnt_r == 16'h0000)
        else $error("count did not wrap to zero");
    a_overflow_flag: assert property ( // RULE10
        inc_path && at_max && !cmp_sel_r |=> timer_event_flag)
        else $error("overflow did not raise flag");
    a_compare_flag: assert property ( // RULE10
        run_r && cmp_sel_r && cnt_r == rld_r |=> timer_event_flag)
        else $error("compare match did not raise flag");
    a_flag_sticky: assert property ( // RULE8
        timer_event_flag && !(wr_run && !wbyte[RUN_FLAG]) |=> timer_event_flag)
        else $error("flag dropped without software clear");
    a_capture_copy: assert property ( // RULE4
        cap_ev[0] |=> cap_val[0] == $past(cnt_r))
        else $error("channel 0 capture lost the count");
    a_capture_then_reset: assert property ( // RULE6 RULE7
        s_capture_reset ##0 (cnt_r != 16'h0000) |=> cnt_r == 16'h0000
        && (!$past(cap_ev[0]) || cap_val[0] == $past(cnt_r))
        && (!$past(cap_ev[1]) || cap_val[1] == $past(cnt_r))
        && (!$past(cap_ev[2]) || cap_val[2] == $past(cnt_r)))
        else $error("capture reset order broken");
    a_edge_reload: assert property ( // RULE1
        reload_hit && !cnt_wr |=> cnt_r == $past(rld_r))
        else $error("edge reload did not load the reload value");
    a_disabled_input: assert property ( // RULE2
        !capen[2] |=> $stable(cap_val[2]))
        else $error("disabled channel 2 acted");
    // An edge with reload off must leave the count to the run logic alone
    a_no_reload_off: assert property ( // RULE1
        !rld_en && trig != 3'h0 && !cnt_wr && !crst_en |=>
        cnt_r == ($past(run_r) ? $past(cnt_r) + 16'h0001 : $past(cnt_r)))
        else $error("reload happened with reload disabled");

endmodule // tcr_timer
`default_nettype wire

// >>> tb/tb_tcr_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_tcr_timer;
    import tcr_pkg::*;

    // ****************************************************************
    // Signals and bookkeeping
    // ****************************************************************
    typedef struct {
        logic [7:0] idx;
        logic       rd;
        logic [7:0] d;
        logic       err;
        logic       ic;
        logic       iv;
    } tcr_note_t;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  pins = 3'h0;
    logic        timer_event_flag;
    logic        irq;
    int          bad_count = 0;
    int          checks = 0;
    logic [31:0] rng = 32'd10;
    tcr_note_t   notes[$];
    tcr_note_t   mon_n;
    logic [15:0] cap_exp[3] = '{16'h0, 16'h0, 16'h0};
    logic [15:0] v;
    logic        got;

    always #25 pclk = ~pclk;

    tcr_timer #(.CHANNELS(3)) DUT (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .capture_input_ch0 (pins[0]),
        .capture_input_ch1 (pins[1]),
        .capture_input_ch2 (pins[2]),
        .timer_event_flag  (timer_event_flag),
        .irq               (irq)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task automatic cmp(input logic [7:0] idx, input string what, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s at reg %h expected %h seen %h", what, idx, e, g);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Request held until pready is sampled high; no latency is assumed
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                        input logic err, input logic ic, input logic iv);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, d};
        notes.push_back('{idx, !w, d, err, ic, iv});
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            bad_count++;
            $display("MISMATCH pready expected 1 seen %b", pready);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d, 1'b0, 1'b0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b0, idx, d, 1'b0, 1'b0, 1'b0);
    endtask

    task automatic rdq(input logic [7:0] idx, input logic [7:0] d, input logic iv);
        xfer(1'b0, idx, d, 1'b0, 1'b1, iv);
    endtask

    task automatic set_cnt(input logic [15:0] c);
        wr(IDX_CNT_LO, c[7:0]);
        wr(IDX_CNT_HI, c[15:8]);
    endtask

    // Pin held six cycles, beyond the four-cycle edge-to-capture latency, so the trigger lands before the next step
    task automatic pin(input int ch, input logic val);
        @(posedge pclk);
        pins[ch] <= val;
        repeat (6) @(posedge pclk);
    endtask

    task automatic tdone(input string name);
        $display("test %s done, mismatches so far %0d", name, bad_count);
    endtask

    // ****************************************************************
    // Result watcher
    // ****************************************************************
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (notes.size() == 0) begin
                bad_count++;
                $display("MISMATCH note queue expected 1 seen 0");
            end else begin
                mon_n = notes.pop_front();
                if (mon_n.rd) cmp(mon_n.idx, "data", {24'h0, mon_n.d}, prdata);
                cmp(mon_n.idx, "error", {31'h0, mon_n.err}, {31'h0, pslverr});
                if (mon_n.ic) cmp(mon_n.idx, "irq", {31'h0, mon_n.iv}, {31'h0, irq});
                if (mon_n.rd && mon_n.idx == IDX_RUN)
                    cmp(mon_n.idx, "flag pin", {31'h0, mon_n.d[7]}, {31'h0, timer_event_flag});
            end
        end
    end

    initial begin
        repeat (30000) @(posedge pclk);
        bad_count++;
        $display("MISMATCH watchdog expected done seen hang");
        finish_test();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 'hC2; i <= 'hDC; i++) begin
            if (i < 'hC4 || i >= 'hD0) rd(8'(i), 8'h00);
        end
        xfer(1'b0, 8'hC4, 8'h00, 1'b1, 1'b0, 1'b0);
        xfer(1'b1, 8'hDD, 8'h5A, 1'b1, 1'b0, 1'b0);
        wr(IDX_MODE, 8'hFF);
        rd(IDX_MODE, 8'hF8);
        wr(IDX_MODE, 8'h00);
        wr(IDX_RUN, 8'h7B);
        rd(IDX_RUN, 8'h01);
        wr(IDX_RUN, 8'h00);
        wr(IDX_CAP_BASE, 8'hAA);
        rd(IDX_CAP_BASE, 8'h00);
        tdone("registers");

        set_cnt(16'h1234);
        repeat (20) @(posedge pclk);
        rd(IDX_CNT_LO, 8'h34);
        rd(IDX_CNT_HI, 8'h12);
        tdone("halt");

        wr(IDX_MASK, 8'h02);
        for (int ch = 0; ch < 3; ch++) begin
            for (int e = 0; e < 4; e++) begin
                wr(IDX_MODE, 8'h10 << ch);
                wr(IDX_CAPCTL, 8'(e) << (2 * ch));
                got = 1'b0;
                v = 16'(xs());
                set_cnt(v);
                pin(ch, 1'b1);
                if (e != 0) begin
                    cap_exp[ch] = v;
                    got = 1'b1;
                end
                v = 16'(xs());
                set_cnt(v);
                pin(ch, 1'b0);
                if (e != 1) begin
                    cap_exp[ch] = v;
                    got = 1'b1;
                end
                rd(IDX_CAP_BASE + 8'(2 * ch), cap_exp[ch][7:0]);
                rd(IDX_CAP_BASE + 8'(2 * ch + 1), cap_exp[ch][15:8]);
                rdq(IDX_STAT, 8'(got) << (ch + 1), got && ch == 0);
                wr(IDX_STAT, 8'h0F);
            end
        end
        wr(IDX_MODE, 8'h00);
        wr(IDX_CAPCTL, 8'h3F);
        set_cnt(16'hBEEF);
        for (int ch = 0; ch < 3; ch++) begin
            pin(ch, 1'b1);
            pin(ch, 1'b0);
            rd(IDX_CAP_BASE + 8'(2 * ch), cap_exp[ch][7:0]);
            rd(IDX_CAP_BASE + 8'(2 * ch + 1), cap_exp[ch][15:8]);
        end
        rd(IDX_STAT, 8'h00);
        tdone("capture");

        wr(IDX_MODE, 8'h18);
        wr(IDX_CAPCTL, 8'h01);
        v = 16'(xs());
        set_cnt(v);
        pin(0, 1'b1);
        cap_exp[0] = v;
        rd(IDX_CAP_BASE, v[7:0]);
        rd(IDX_CAP_BASE + 8'h01, v[15:8]);
        rd(IDX_CNT_LO, 8'h00);
        rd(IDX_CNT_HI, 8'h00);
        pin(0, 1'b0);
        tdone("capture reset");

        wr(IDX_MODE, 8'h90);
        wr(IDX_RLD_LO, 8'hC5);
        wr(IDX_RLD_HI, 8'h7A);
        set_cnt(16'h0102);
        pin(0, 1'b1);
        rd(IDX_CNT_LO, 8'hC5);
        rd(IDX_CNT_HI, 8'h7A);
        rd(IDX_CAP_BASE, cap_exp[0][7:0]);
        pin(0, 1'b0);
        wr(IDX_MODE, 8'h00);
        wr(IDX_STAT, 8'h0F);
        tdone("reload");

        set_cnt(16'hFFFF);
        wr(IDX_RUN, 8'h04);
        repeat (10) @(posedge pclk);
        wr(IDX_RUN, 8'h80);
        rd(IDX_RUN, 8'h80);
        rd(IDX_CNT_HI, 8'h00);
        rdq(IDX_STAT, 8'h01, 1'b0);
        wr(IDX_MASK, 8'h03);
        rdq(IDX_STAT, 8'h01, 1'b1);
        wr(IDX_STAT, 8'h01);
        rdq(IDX_STAT, 8'h00, 1'b0);
        wr(IDX_RUN, 8'h00);
        rd(IDX_RUN, 8'h00);
        tdone("overflow");

        for (int k = 0; k < 2; k++) begin
            set_cnt(16'h0000);
            wr(IDX_RLD_LO, k == 0 ? 8'h20 : 8'h00);
            wr(IDX_RLD_HI, k == 0 ? 8'h00 : 8'h10);
            wr(IDX_RUN, 8'h05);
            repeat (50) @(posedge pclk);
            wr(IDX_RUN, 8'h81);
            rd(IDX_RUN, k == 0 ? 8'h81 : 8'h01);
            rd(IDX_CNT_HI, 8'h00);
            wr(IDX_RUN, 8'h00);
            wr(IDX_STAT, 8'h0F);
        end
        tdone("compare");

        wr(IDX_MODE, 8'h80);
        set_cnt(16'hFFFF);
        wr(IDX_RUN, 8'h04);
        repeat (10) @(posedge pclk);
        wr(IDX_RUN, 8'h00);
        rd(IDX_CNT_HI, 8'h10);
        wr(IDX_MODE, 8'h00);
        wr(IDX_STAT, 8'h0F);
        tdone("overflow reload");
        finish_test();
    end

endmodule // tb_tcr_timer
`default_nettype wire
